// ---- hw/flf_pkg.sv ----
package flf_pkg;

  // Filter geometry
  localparam int TAPS          = 128;
  localparam int LANES         = 32;
  localparam int LANE_RATE_MBPS = 125;
  localparam int PASS_MAX      = 4;
  localparam int DEC_W         = 2;
  localparam int DEC_MAX_LOG   = 2;
  localparam int COEF_W        = 12;
  localparam int SMP_W         = 2;
  localparam int LVL_W         = 16;
  localparam int GAIN_W        = 16;

  // Clock
  localparam int CLK_MHZ       = 100;

  // Register bus
  localparam int REG_W         = 32;
  localparam int ADDR_W        = 6;
  localparam int BE_W          = REG_W / 8;

  // Byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_THR_LO    = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_THR_MID   = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_THR_HI    = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_COEF_ADDR = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_COEF_DATA = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_GAIN      = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_LEVEL     = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_LAST_SUM  = 6'h24;

  // Field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_BYP_BIT  = 1;
  localparam int CTRL_DEC_LSB  = 2;
  localparam int ST_BYP_BIT    = 0;
  localparam int ST_VALID_BIT  = 1;
  localparam int ST_PASS_LSB   = 4;

  // Reset values
  localparam logic [REG_W-1:0] THR_LO_RST  = 32'hFFFF_FC00;
  localparam logic [REG_W-1:0] THR_MID_RST = 32'h0000_0000;
  localparam logic [REG_W-1:0] THR_HI_RST  = 32'h0000_0400;
  localparam logic [REG_W-1:0] GAIN_RST    = 32'h0000_8000;

  // Output sample levels
  typedef enum logic [SMP_W-1:0] {
    FLF_NEG_HI = 2'h0,
    FLF_NEG_LO = 2'h1,
    FLF_POS_LO = 2'h2,
    FLF_POS_HI = 2'h3
  } flf_level_t;

  // Map a sum onto four levels; beyond the outer thresholds it saturates
  function automatic logic [SMP_W-1:0] flf_quant(
    input logic signed [REG_W-1:0] sum,
    input logic signed [REG_W-1:0] lo,
    input logic signed [REG_W-1:0] mid,
    input logic signed [REG_W-1:0] hi);
    if (sum < lo) begin
      return FLF_NEG_HI;
    end else if (sum < mid) begin
      return FLF_NEG_LO;
    end else if (sum < hi) begin
      return FLF_POS_LO;
    end
    return FLF_POS_HI;
  endfunction : flf_quant

endpackage : flf_pkg

// ---- hw/flf_tap_lut.sv ----
`timescale 1ns/1ps
module flf_tap_lut #(
  parameter int TAPS   = flf_pkg::TAPS,
  parameter int PASSES = flf_pkg::PASS_MAX,
  parameter int COEF_W = flf_pkg::COEF_W,
  parameter int PW     = $clog2(PASSES),
  parameter int LA_W   = $clog2(PASSES * TAPS * 4)
) (
  // Clock
  input  wire logic                             mclk_i,
  // Write port
  input  wire logic                             we_i,
  input  wire logic [LA_W-1:0]                  waddr_i,
  input  wire logic [COEF_W-1:0]                wdata_i,
  // Per-tap selection
  input  wire logic [PW-1:0]                    pass_i,
  input  wire logic [TAPS-1:0][flf_pkg::SMP_W-1:0] sel_i,
  output      logic [TAPS-1:0][COEF_W-1:0]      rd_o
);
  import flf_pkg::*;

  localparam int DEPTH = PASSES * TAPS * 4;

  typedef struct packed {
    logic [DEPTH-1:0][COEF_W-1:0] mem;
    logic [TAPS-1:0][COEF_W-1:0]  rd;
  } flf_lut_t;

  flf_lut_t s_q;
  flf_lut_t s_d;

  // Four precomputed products per tap; the sample code picks one
  always_comb begin
    s_d = s_q;
    if (we_i) begin
      s_d.mem[waddr_i] = wdata_i;
    end
    for (int t = 0; t < TAPS; t++) begin
      s_d.rd[t] = s_q.mem[(int'(pass_i) * TAPS + t) * 4 + int'(sel_i[t])];
    end
  end

  // Contents are RAM: no reset, software loads them
  always_ff @(posedge mclk_i) begin
    s_q <= s_d;
  end

  assign rd_o = s_q.rd;

endmodule : flf_tap_lut

// ---- hw/flf_fir.sv ----
// Register access over Avalon-MM and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - Incoming two-bit samples run through a delay line of 516 stages, 129 per pass with 128 of them tapped.
// - Each cycle the 128 tapped stages of the current pass are weighted by their coefficients and summed.
// - Each next cycle the line moves one stage and the sum is redone.
// - One of 32 lanes of a 4 Gb/s stream, one sample per clock.
// - Coefficients live in writable RAM that software can reload.
// - Each tap selects one of four stored products instead of multiplying.
// - Each bandwidth halving, up to two, halves output rate and doubles taps.
// - The wide sum is cut to a two-bit sample for the correlator.
// - At full bandwidth a bypass passes raw samples through untouched.
// - Gain settings and level readings are reachable from software.
module flf_fir #(
  parameter int TAPS     = flf_pkg::TAPS,
  parameter int PASS_MAX = flf_pkg::PASS_MAX,
  parameter int COEF_W   = flf_pkg::COEF_W
) (
  // Clock and reset
  input  wire logic                         mclk_i,
  input  wire logic                         srst_i,
  // Sample stream
  input  wire logic [flf_pkg::SMP_W-1:0]    sample_i,
  output      logic [flf_pkg::SMP_W-1:0]    sample_o,
  output      logic                         valid_o,
  // Gain control and level detector
  output      logic [flf_pkg::GAIN_W-1:0]   gain_o,
  input  wire logic [flf_pkg::LVL_W-1:0]    level_i,
  // Avalon-MM slave
  input  wire logic [flf_pkg::ADDR_W-1:0]   avs_address_i,
  input  wire logic                         avs_read_i,
  input  wire logic                         avs_write_i,
  input  wire logic [flf_pkg::REG_W-1:0]    avs_writedata_i,
  input  wire logic [flf_pkg::BE_W-1:0]     avs_byteenable_i,
  output      logic [flf_pkg::REG_W-1:0]    avs_readdata_o,
  output      logic                         avs_waitrequest_o
);
  import flf_pkg::*;

  localparam int PW       = $clog2(PASS_MAX);
  localparam int LINE_LEN = PASS_MAX * (TAPS + 1);
  localparam int LA_W     = $clog2(PASS_MAX * TAPS * 4);
  localparam int AW       = COEF_W + $clog2(TAPS) + $clog2(PASS_MAX) + 1;

  typedef struct packed {
    logic [LINE_LEN-1:0][SMP_W-1:0] line;
    logic [PW-1:0]                  pass;
    logic [PW-1:0]                  pass_rd;
    logic                           rd_vld;
    logic signed [AW-1:0]           acc;
    logic signed [AW-1:0]           last_sum;
    logic [SMP_W-1:0]               sample;
    logic                           valid;
    logic                           byp;
    logic                           en;
    logic                           bypass;
    logic [DEC_W-1:0]               dec;
    logic signed [AW-1:0]           thr_lo;
    logic signed [AW-1:0]           thr_mid;
    logic signed [AW-1:0]           thr_hi;
    logic [LA_W-1:0]                coef_addr;
    logic                           lut_we;
    logic [LA_W-1:0]                lut_addr;
    logic [COEF_W-1:0]              lut_data;
    logic [GAIN_W-1:0]              gain;
    logic                           wait_q;
    logic [REG_W-1:0]               rdata;
  } flf_state_t;

  flf_state_t                    s_q;
  flf_state_t                    s_d;
  logic [TAPS-1:0][SMP_W-1:0]    sel;
  logic [TAPS-1:0][COEF_W-1:0]   rd;
  logic signed [AW-1:0]          sum;
  logic signed [AW-1:0]          total;
  logic [PW-1:0]                 last_pass;
  logic                          byp_active;
  logic                          take;
  logic [REG_W-1:0]              wval;

  // Delay-line stage feeding tap t during pass p; the extra stage per
  // pass cancels the one-stage shift that happens between passes
  function automatic int stage_idx(input int p, input int t);
    return p * (TAPS + 1) + t;
  endfunction : stage_idx

  // Highest pass index for a decimation setting, clamped to the RAM size
  function automatic logic [PW-1:0] pass_last(input logic [DEC_W-1:0] d);
    int n;
    n = (d > DEC_W'(DEC_MAX_LOG)) ? DEC_MAX_LOG : int'(d);
    return PW'((1 << n) - 1);
  endfunction : pass_last

  function automatic logic [REG_W-1:0] be_merge(
    input logic [REG_W-1:0] old_v,
    input logic [REG_W-1:0] new_v,
    input logic [BE_W-1:0]  be);
    logic [REG_W-1:0] r;
    r = old_v;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : be_merge

  // Per-tap products for the current pass
  always_comb begin
    for (int t = 0; t < TAPS; t++) begin
      sel[t] = s_q.line[stage_idx(int'(s_q.pass), t)];
    end
  end

  flf_tap_lut #(
    .TAPS   (TAPS),
    .PASSES (PASS_MAX),
    .COEF_W (COEF_W),
    .PW     (PW),
    .LA_W   (LA_W)
  ) u_lut (
    .mclk_i  (mclk_i),
    .we_i    (s_q.lut_we),
    .waddr_i (s_q.lut_addr),
    .wdata_i (s_q.lut_data),
    .pass_i  (s_q.pass),
    .sel_i   (sel),
    .rd_o    (rd)
  );

  // Adder over all taps; sign-extended so no partial sum can wrap
  always_comb begin
    sum = '0;
    for (int t = 0; t < TAPS; t++) begin
      sum = sum + AW'($signed(rd[t]));
    end
  end

  assign total      = (s_q.pass_rd == '0) ? sum : s_q.acc + sum;
  assign last_pass  = pass_last(s_q.dec);
  assign byp_active = s_q.bypass && (s_q.dec == '0);
  assign take       = (avs_read_i || avs_write_i) && !s_q.wait_q;

  always_comb begin
    wval = '0;
    unique case (avs_address_i)
      OFS_CTRL:      wval[CTRL_DEC_LSB +: DEC_W] = s_q.dec;
      OFS_THR_LO:    wval = REG_W'(s_q.thr_lo);
      OFS_THR_MID:   wval = REG_W'(s_q.thr_mid);
      OFS_THR_HI:    wval = REG_W'(s_q.thr_hi);
      OFS_COEF_ADDR: wval[LA_W-1:0] = s_q.coef_addr;
      OFS_GAIN:      wval[GAIN_W-1:0] = s_q.gain;
      default:       wval = '0;
    endcase
    if (avs_address_i == OFS_CTRL) begin
      wval[CTRL_EN_BIT]  = s_q.en;
      wval[CTRL_BYP_BIT] = s_q.bypass;
    end
    wval = be_merge(wval, avs_writedata_i, avs_byteenable_i);
  end

  always_comb begin
    s_d        = s_q;
    s_d.lut_we = 1'b0;
    s_d.valid  = 1'b0;

    // Shift one stage per clock, whatever the mode
    s_d.line = {s_q.line[LINE_LEN-2:0], sample_i};

    // Passes walk 0..last; spare cycles reuse older history
    s_d.pass    = (s_q.pass == last_pass) ? '0 : s_q.pass + 1'b1;
    s_d.pass_rd = s_q.pass;
    s_d.rd_vld  = s_q.en && !byp_active;
    s_d.byp     = byp_active;

    if (s_q.rd_vld) begin
      s_d.acc = total;
      if (s_q.pass_rd == last_pass) begin
        s_d.last_sum = total;
        s_d.sample   = flf_quant(REG_W'(total), REG_W'(s_q.thr_lo),
                                 REG_W'(s_q.thr_mid),
                                 REG_W'(s_q.thr_hi));
        s_d.valid    = 1'b1;
      end
    end

    // Raw sample straight through, no truncation loss
    if (byp_active && s_q.en) begin
      s_d.sample = sample_i;
      s_d.valid  = 1'b1;
    end

    // Bus: one wait cycle, then a one-cycle answer
    s_d.wait_q = !(avs_read_i || avs_write_i) || !s_q.wait_q;
    if ((avs_read_i || avs_write_i) && s_q.wait_q) begin
      s_d.rdata = '0;
      unique case (avs_address_i)
        OFS_CTRL: begin
          s_d.rdata[CTRL_EN_BIT]  = s_q.en;
          s_d.rdata[CTRL_BYP_BIT] = s_q.bypass;
          s_d.rdata[CTRL_DEC_LSB +: DEC_W] = s_q.dec;
        end
        OFS_STATUS: begin
          s_d.rdata[ST_BYP_BIT]   = s_q.byp;
          s_d.rdata[ST_VALID_BIT] = s_q.rd_vld;
          s_d.rdata[ST_PASS_LSB +: PW] = s_q.pass;
        end
        OFS_THR_LO:    s_d.rdata = REG_W'(s_q.thr_lo);
        OFS_THR_MID:   s_d.rdata = REG_W'(s_q.thr_mid);
        OFS_THR_HI:    s_d.rdata = REG_W'(s_q.thr_hi);
        OFS_COEF_ADDR: s_d.rdata[LA_W-1:0] = s_q.coef_addr;
        OFS_GAIN:      s_d.rdata[GAIN_W-1:0] = s_q.gain;
        OFS_LEVEL:     s_d.rdata[LVL_W-1:0] = level_i;
        OFS_LAST_SUM:  s_d.rdata = REG_W'(s_q.last_sum);
        default:       s_d.rdata = '0;
      endcase
    end

    if (take && avs_write_i) begin
      unique case (avs_address_i)
        OFS_CTRL: begin
          s_d.en     = wval[CTRL_EN_BIT];
          s_d.bypass = wval[CTRL_BYP_BIT];
          s_d.dec    = wval[CTRL_DEC_LSB +: DEC_W];
          // Restart the pass walk so no output mixes two settings
          s_d.pass   = '0;
          s_d.rd_vld = 1'b0;
        end
        OFS_THR_LO:    s_d.thr_lo  = AW'(signed'(wval));
        OFS_THR_MID:   s_d.thr_mid = AW'(signed'(wval));
        OFS_THR_HI:    s_d.thr_hi  = AW'(signed'(wval));
        OFS_COEF_ADDR: s_d.coef_addr = wval[LA_W-1:0];
        OFS_COEF_DATA: begin
          s_d.lut_we    = 1'b1;
          s_d.lut_addr  = s_q.coef_addr;
          s_d.lut_data  = wval[COEF_W-1:0];
          s_d.coef_addr = s_q.coef_addr + 1'b1;
        end
        OFS_GAIN:      s_d.gain = wval[GAIN_W-1:0];
        default:       s_d.gain = s_q.gain;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_q         <= '0;
      s_q.wait_q  <= 1'b1;
      s_q.thr_lo  <= AW'(signed'(THR_LO_RST));
      s_q.thr_mid <= AW'(signed'(THR_MID_RST));
      s_q.thr_hi  <= AW'(signed'(THR_HI_RST));
      s_q.gain    <= GAIN_RST[GAIN_W-1:0];
    end else begin
      s_q <= s_d;
    end
  end

  assign sample_o          = s_q.sample;
  assign valid_o           = s_q.valid;
  assign gain_o            = s_q.gain;
  assign avs_readdata_o    = s_q.rdata;
  assign avs_waitrequest_o = s_q.wait_q;

  // Stage 4 holds the sample taken five edges earlier; six clean edges
  // so a cleared stage never stands in for a real sample
  chk_line_depth: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    !srst_i [*6] |-> s_q.line[4] == $past(sample_i, 5))
    else $error("delay line does not advance one stage per clock");

  // First pass of a group loads, later passes add
  chk_acc_first: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (s_q.rd_vld && s_q.pass_rd == '0) |=> s_q.acc == $past(sum))
    else $error("first pass did not restart the accumulator");

  sequence seq_half_rate;
    !valid_o ##1 valid_o;
  endsequence

  // Two passes give one output every second clock; a bus write around
  // the pulse restarts the pass walk, so those cycles are left out
  chk_half_rate: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (valid_o && !s_q.byp && s_q.dec == DEC_W'(1) && s_q.en
      && $stable(s_q.dec) && !$past(take) && !take) ##1 !take
      |-> seq_half_rate)
    else $error("decimated output rate is wrong");

  // A threshold write on the launching edge would skew the recompute
  chk_trunc_sat: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (valid_o && !s_q.byp && !$past(take)) |-> sample_o == flf_quant(
      REG_W'(s_q.last_sum), REG_W'(s_q.thr_lo),
      REG_W'(s_q.thr_mid), REG_W'(s_q.thr_hi)))
    else $error("truncated sample does not match thresholds");

  chk_bypass_raw: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (byp_active && s_q.en && !take) |=>
      valid_o && sample_o == $past(sample_i))
    else $error("bypass did not pass the raw sample");

  sequence seq_bus_answer;
    avs_waitrequest_o ##1 !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence

  chk_bus_answer: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    $rose(avs_read_i || avs_write_i) && avs_waitrequest_o
      |-> seq_bus_answer)
    else $error("bus answer not one wait cycle then one ready cycle");

  chk_gain_write: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (take && avs_write_i && avs_address_i == OFS_GAIN
      && avs_byteenable_i == '1)
      |=> gain_o == $past(avs_writedata_i[GAIN_W-1:0]))
    else $error("gain write did not reach gain output");

  chk_level_read: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (avs_read_i && s_q.wait_q && avs_address_i == OFS_LEVEL)
      |=> avs_readdata_o == REG_W'($past(level_i)))
    else $error("level reading not returned");

  chk_coef_write: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (take && avs_write_i && avs_address_i == OFS_COEF_DATA)
      |=> s_q.lut_we && s_q.lut_addr == $past(s_q.coef_addr)
          && s_q.coef_addr == $past(s_q.coef_addr) + 1'b1)
    else $error("coefficient write not issued to the table");

endmodule : flf_fir

// ---- bench/flf_far_end.sv ----
`timescale 1ns/1ps
// Sampler demux lane upstream, correlator sink downstream
module flf_far_end (
  // Clock and bench control
  input  wire logic                     mclk_i,
  input  wire logic [flf_pkg::SMP_W-1:0] code_i,
  input  wire logic [flf_pkg::LVL_W-1:0] lvl_i,
  // Filter side
  output      logic [flf_pkg::SMP_W-1:0] sample_o,
  output      logic [flf_pkg::LVL_W-1:0] level_o,
  input  wire logic                     valid_i,
  output      int                       n_valid_o
);
  import flf_pkg::*;
  initial sample_o = '0;
  initial level_o = '0;
  initial n_valid_o = 0;
  // One code per lane clock, registered as a demux lane would be
  always @(posedge mclk_i) begin
    sample_o <= code_i;
    level_o  <= lvl_i;
    // Sink counts pulses so the bench can check the output rate
    if (valid_i === 1'b1) n_valid_o <= n_valid_o + 1;
  end
endmodule : flf_far_end

// ---- bench/four_level_fir_filter_test.sv ----
`timescale 1ns/1ps
module four_level_fir_filter_test;
  import flf_pkg::*;
  logic              mclk_i = 1'b0;
  logic              srst_i = 1'b1;
  logic [SMP_W-1:0]  code = '0, sample_i, sample_o, s;
  logic              valid_o, rd = 1'b0, wr = 1'b0, wt;
  logic [GAIN_W-1:0] gain_o;
  logic [LVL_W-1:0]  level_i, lvl = 16'h1357;
  logic [ADDR_W-1:0] adr = '0;
  logic [REG_W-1:0]  wd = '0, rdat, r;
  logic [BE_W-1:0]   be = '0;
  int miscompares = 0, n_compared = 0, seed = 32'h6009, cyc = 0, nv;
  int coef[2048];
  int lo = -200, mid = 0, hi = 200;
  logic [ADDR_W-1:0] ra[6] = '{OFS_THR_LO, OFS_THR_MID, OFS_THR_HI,
                               OFS_GAIN, 6'h28, 6'h3C};
  logic [REG_W-1:0] rv[6] = '{THR_LO_RST, THR_MID_RST, THR_HI_RST,
                              GAIN_RST, 32'h0000_0000, 32'h0000_0000};

  always #5 mclk_i = ~mclk_i;

  flf_fir dut (.mclk_i(mclk_i), .srst_i(srst_i), .sample_i(sample_i),
    .sample_o(sample_o), .valid_o(valid_o), .gain_o(gain_o),
    .level_i(level_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt));

  flf_far_end far (.mclk_i(mclk_i), .code_i(code), .lvl_i(lvl),
    .sample_o(sample_i), .level_o(level_i), .valid_i(valid_o),
    .n_valid_o(nv));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // Request held until the rising edge that samples wait low; data is
  // taken and the request dropped at that same edge
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [REG_W-1:0] d, input logic [BE_W-1:0] b,
                     output logic [REG_W-1:0] q);
    @(posedge mclk_i);
    adr <= a;
    wd  <= d;
    be  <= b;
    wr  <= w;
    rd  <= !w;
    do @(posedge mclk_i); while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus

  task automatic wr32(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [REG_W-1:0] q;
    bus(1'b1, a, d, 4'hF, q);
  endtask : wr32

  function automatic logic [1:0] q4(input int v);
    return v < lo ? 2'h0 : v < mid ? 2'h1 : v < hi ? 2'h2 : 2'h3;
  endfunction : q4

  // Constant input fills the whole extended line, so the sum no longer
  // depends on pipeline alignment
  task automatic run(input int d, input int x);
    int e, n0;
    code <= SMP_W'(x);
    wr32(OFS_CTRL, (d << CTRL_DEC_LSB) | 1);
    repeat (700) @(posedge mclk_i);
    n0 = nv;
    repeat (64) @(posedge mclk_i);
    chk(nv - n0, 64 >> d);
    e = 0;
    for (int p = 0; p < (1 << d); p++)
      for (int t = 0; t < TAPS; t++) e += coef[(p * TAPS + t) * 4 + x];
    bus(1'b0, OFS_LAST_SUM, '0, 4'hF, r);
    chk(r, e);
    chk(sample_o, q4(e));
  endtask : run

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    repeat (12) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(negedge mclk_i);
    chk(valid_o, 1'b0);
    chk(wt, 1'b1);
    chk(gain_o, 16'h8000);
    wr32(6'h3C, 32'hFFFF_FFFF);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ra[i], '0, 4'hF, r);
      chk(r, rv[i]);
    end
    $display("test reset_values done");
    // Byte lane 0 only, upper lane keeps its reset value
    bus(1'b1, OFS_GAIN, 32'h0000_1234, 4'h1, r);
    bus(1'b0, OFS_GAIN, '0, 4'hF, r);
    chk(r, 32'h0000_8034);
    chk(gain_o, 16'h8034);
    wr32(OFS_GAIN, 32'h0000_5A5A);
    @(negedge mclk_i);
    chk(gain_o, 16'h5A5A);
    wr32(OFS_LEVEL, 32'h0000_FFFF);
    bus(1'b0, OFS_LEVEL, '0, 4'hF, r);
    chk(r, {16'h0000, lvl});
    $display("test gain_level done");
    // Small coefficients keep sums near the thresholds
    wr32(OFS_COEF_ADDR, 0);
    for (int i = 0; i < 2048; i++) begin
      coef[i] = $random(seed) % 8;
      wr32(OFS_COEF_DATA, coef[i]);
    end
    wr32(OFS_THR_LO, lo);
    wr32(OFS_THR_MID, mid);
    wr32(OFS_THR_HI, hi);
    for (int d = 0; d < 3; d++)
      for (int x = 0; x < 4; x++) run(d, x);
    $display("test filter_sums done");
    coef[22] = coef[22] + 150;
    wr32(OFS_COEF_ADDR, 22);
    wr32(OFS_COEF_DATA, coef[22]);
    run(0, 2);
    $display("test coef_reload done");
    wr32(OFS_CTRL, 0);
    repeat (20) @(posedge mclk_i);
    r = nv;
    repeat (64) @(posedge mclk_i);
    chk(nv - r, 0);
    $display("test disable done");
    wr32(OFS_CTRL, 32'h0000_0007);
    bus(1'b0, OFS_STATUS, '0, 4'hF, r);
    chk(r[ST_BYP_BIT], 1'b0);
    wr32(OFS_CTRL, 32'h0000_0003);
    bus(1'b0, OFS_STATUS, '0, 4'hF, r);
    chk(r[ST_BYP_BIT], 1'b1);
    repeat (4) @(posedge mclk_i);
    @(negedge mclk_i);
    s = sample_i;
    repeat (100) begin
      @(posedge mclk_i);
      code <= SMP_W'($random(seed));
      @(negedge mclk_i);
      chk(sample_o, s);
      chk(valid_o, 1'b1);
      s = sample_i;
    end
    $display("test bypass done");
    stop_test();
  end
endmodule : four_level_fir_filter_test
